// >>> mabp_defines.vh
/*
 * Constants for the multiplexed address/data bus pin block.
 * Assumes a 20 MHz processor clock and inclusion by bare name.
 */
`ifndef MABP_DEFINES_VH
`define MABP_DEFINES_VH

// ****************************************
// Cycle type encoding {lowest line, upper byte enable}
// ****************************************
`define MABP_TYPE_WORD      2'b00
`define MABP_TYPE_EVEN      2'b01
`define MABP_TYPE_ODD       2'b10
`define MABP_TYPE_REFRESH   2'b11

// ****************************************
// Field positions and reset values
// ****************************************
`define MABP_UPPER_MSB      19
`define MABP_UPPER_LSB      16
`define MABP_LOW_MSB        15
`define MABP_UPPER_IDLE     4'h0
`define MABP_DATA_IDLE      16'h0000

// ****************************************
// Timing: clock rate and phase lengths in cycles
// ****************************************
`define MABP_CLOCK_HZ       20000000
`define MABP_ADDR_CYCLES    1
`define MABP_DATA_CYCLES    2
`define MABP_BAUD_DIV_MIN   2

`endif

// >>> mabp_bus.v
/*
 * Bus pin sequencer: address phase, strobe, data phase, cycle type
 * encoding, coprocessor busy stall and alternate baud clock sampling.
 * Assumes the core holds a request until it is accepted, and that the
 * testbench resolves the shared lines from the enables.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mabp_defines.vh"

// How it works
// - The upper four address bits are driven in the address phase for latching.
// - The upper address lines read as zero throughout the data phase.
// - The low sixteen address bits are driven on the shared lines in the address phase.
// - Data phase carries write data from the device or read data from the addressed party.
// - The active-high address strobe is raised in the address phase of each cycle.
// - The upper-byte enable goes low when the cycle uses the upper data byte.
// - Lowest line with the upper-byte enable encode word, even, odd and refresh.
// - A high coprocessor busy input stalls the device during coprocessor work.
// - The device resumes once busy is sampled low.
module mabp_bus (
	input  wire        clock_i,
	input  wire        rst_b_i,
	input  wire        req_valid_i,
	output wire        req_ready_o,
	input  wire [19:0] req_addr_i,
	input  wire        req_write_i,
	input  wire        req_byte_i,
	input  wire        req_refresh_i,
	input  wire [15:0] req_wdata_i,
	input  wire        copro_op_i,
	output reg         rsp_valid_o,
	output reg  [15:0] rsp_rdata_o,
	output wire        stall_o,
	input  wire [15:0] muxed_line_i,
	output reg  [15:0] muxed_line_o,
	output reg  [15:0] muxed_line_oe_b_o,
	output reg  [3:0]  upper_addr_line_o,
	output reg         addr_strobe_o,
	output reg         upper_byte_en_b_o,
	input  wire        copro_busy_i,
	input  wire        serial0_alt_baud_clock_i,
	input  wire        serial1_alt_baud_clock_i,
	output wire        serial0_baud_tick_o,
	output wire        serial1_baud_tick_o
);

	localparam ST_IDLE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_DATA = 2'h2;

	reg  [1:0]  state;
	reg  [1:0]  count;
	reg  [1:0]  next_state;
	reg  [1:0]  next_count;
	reg         cur_write;
	reg  [15:0] cur_wdata;
	reg  [1:0]  sync_busy;
	wire        busy_s;
	wire [1:0]  cycle_type;
	wire        addr_done;
	wire        data_done;
	wire [1:0]  baud_pin;
	wire [1:0]  baud_tick;

	// ****************************************
	// Cycle type function
	// ****************************************
	// Type encoding
	function [1:0] mabp_type;
		input       refresh;
		input       byte_op;
		input       a0;
		begin
			if (refresh)
				mabp_type = `MABP_TYPE_REFRESH;
			else if (!byte_op)
				mabp_type = `MABP_TYPE_WORD;
			else if (a0)
				mabp_type = `MABP_TYPE_ODD;
			else
				mabp_type = `MABP_TYPE_EVEN;
		end
	endfunction

	assign cycle_type = mabp_type(req_refresh_i, req_byte_i, req_addr_i[0]);

	// ****************************************
	// Input synchronisers
	// ****************************************
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_busy <= 2'h0;
		end else begin
			sync_busy <= {sync_busy[0], copro_busy_i};
		end
	end

	// ****************************************
	// Alternate baud clock edge detectors
	// ****************************************
	assign baud_pin = {serial1_alt_baud_clock_i, serial0_alt_baud_clock_i};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_baud
			reg [2:0] sync_pin;
			always @(posedge clock_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					sync_pin <= 3'h0;
				end else begin
					sync_pin <= {sync_pin[1:0], baud_pin[gi]};
				end
			end
			// Rising-edge tick, valid only up to half rate
			assign baud_tick[gi] = sync_pin[1] & ~sync_pin[2];
		end
	endgenerate

	assign serial0_baud_tick_o = baud_tick[0];
	assign serial1_baud_tick_o = baud_tick[1];

	assign busy_s = sync_busy[1];
	// Stall while busy during coprocessor work
	assign stall_o     = copro_op_i & busy_s;
	// Accept again once busy reads low
	assign req_ready_o = (state == ST_IDLE) & ~stall_o;

	// ****************************************
	// Phase counter and next state
	// ****************************************
	assign addr_done = (count == `MABP_ADDR_CYCLES - 1);
	assign data_done = (count == `MABP_DATA_CYCLES - 1);

	always @* begin
		next_state = state;
		next_count = count;
		case (state)
		ST_IDLE: begin
			if (req_valid_i && req_ready_o) begin
				next_state = ST_ADDR;
				next_count = 2'h0;
			end
		end
		ST_ADDR: begin
			if (addr_done) begin
				next_state = ST_DATA;
				next_count = 2'h0;
			end else begin
				next_count = count + 2'h1;
			end
		end
		ST_DATA: begin
			if (data_done) begin
				next_state = ST_IDLE;
				next_count = 2'h0;
			end else begin
				next_count = count + 2'h1;
			end
		end
		default: begin
			next_state = ST_IDLE;
			next_count = 2'h0;
		end
		endcase
	end

	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state             <= ST_IDLE;
			count             <= 2'h0;
			cur_write         <= 1'b0;
			cur_wdata         <= `MABP_DATA_IDLE;
			muxed_line_o      <= `MABP_DATA_IDLE;
			muxed_line_oe_b_o <= 16'hffff;
			upper_addr_line_o <= `MABP_UPPER_IDLE;
			addr_strobe_o     <= 1'b0;
			upper_byte_en_b_o <= 1'b1;
			rsp_valid_o       <= 1'b0;
			rsp_rdata_o       <= `MABP_DATA_IDLE;
		end else begin
			state       <= next_state;
			count       <= next_count;
			rsp_valid_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					cur_write         <= req_write_i;
					cur_wdata         <= req_wdata_i;
					upper_addr_line_o <= req_addr_i[`MABP_UPPER_MSB:`MABP_UPPER_LSB];
					muxed_line_o      <= req_addr_i[`MABP_LOW_MSB:0];
					muxed_line_oe_b_o <= 16'h0000;
					addr_strobe_o     <= 1'b1;
					upper_byte_en_b_o <= cycle_type[0];
				end
			end
			ST_ADDR: begin
				if (addr_done) begin
					addr_strobe_o     <= 1'b0;
					// Upper lines zero in data phase
					upper_addr_line_o <= `MABP_UPPER_IDLE;
					muxed_line_o      <= cur_write ? cur_wdata : `MABP_DATA_IDLE;
					muxed_line_oe_b_o <= cur_write ? 16'h0000 : 16'hffff;
				end
			end
			ST_DATA: begin
				if (data_done) begin
					muxed_line_oe_b_o <= 16'hffff;
					muxed_line_o      <= `MABP_DATA_IDLE;
					upper_byte_en_b_o <= 1'b1;
					rsp_rdata_o       <= cur_write ? `MABP_DATA_IDLE : muxed_line_i;
					rsp_valid_o       <= 1'b1;
				end
			end
			default: begin
				rsp_valid_o <= 1'b0;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> mabp_bus_sva.sv
/* Port checker for mabp_bus.
 * Assumes binding by port name. */
`timescale 1ns/100ps
`default_nettype none
module mabp_chk (
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic        req_valid_i,
	input wire logic        req_ready_o,
	input wire logic [19:0] req_addr_i,
	input wire logic        copro_op_i,
	input wire logic        copro_busy_i,
	input wire logic        stall_o,
	input wire logic [15:0] muxed_line_o,
	input wire logic [15:0] muxed_line_oe_b_o,
	input wire logic [3:0]  upper_addr_line_o,
	input wire logic        addr_strobe_o,
	input wire logic        upper_byte_en_b_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	wire logic acc = req_valid_i & req_ready_o;
	sequence s_data;
		!addr_strobe_o && upper_addr_line_o == 4'h0;
	endsequence
	chk_upper_addr: assert property (acc |=> upper_addr_line_o == $past(req_addr_i[19:16]))
		else $error("upper address");
	chk_upper_zero: assert property (acc |=> addr_strobe_o ##1 s_data [*2])
		else $error("data phase upper");
	chk_low_addr: assert property (acc |=> muxed_line_o == $past(req_addr_i[15:0]) && muxed_line_oe_b_o == 16'h0)
		else $error("low address");
	chk_strobe_once: assert property ($rose(addr_strobe_o) |=> !addr_strobe_o [*2])
		else $error("strobe");
	chk_data_held: assert property (acc |-> ##3 $stable(muxed_line_oe_b_o))
		else $error("data drive");
	chk_ube_held: assert property (acc |-> ##2 $stable(upper_byte_en_b_o) [*2])
		else $error("byte enable");
	chk_busy_stall: assert property ($past(rst_b_i, 2) |-> stall_o == (copro_op_i && $past(copro_busy_i, 2)))
		else $error("stall");
	chk_stall_hold: assert property (stall_o |-> !req_ready_o)
		else $error("ready in stall");
endmodule
bind mabp_bus mabp_chk i_mabp_chk (.*);
`default_nettype wire

// >>> mabp_far.sv
/* Far-side memory and baud clock source.
 * Assumes one strobe cycle before two data cycles. */
`timescale 1ns/100ps
`default_nettype none
module mabp_far (
	input  wire logic        clock_i,
	input  wire logic [15:0] muxed_line_o,
	input  wire logic [15:0] muxed_line_oe_b_o,
	input  wire logic        addr_strobe_o,
	output wire logic [15:0] muxed_line_i,
	output wire logic        serial0_alt_baud_clock_i,
	output wire logic        serial1_alt_baud_clock_i
);
	logic [15:0] mem [0:15];
	logic [3:0]  adr;
	logic [1:0]  ph = 2'h0;
	logic [1:0]  div = 2'h0;
	always @(posedge clock_i) begin
		div <= div + 2'h1;
		ph <= addr_strobe_o ? 2'h2 : ph - {1'b0, ph != 2'h0};
		if (addr_strobe_o) adr <= muxed_line_o[3:0];
		if (ph != 2'h0 && muxed_line_oe_b_o == 16'h0) mem[adr] <= muxed_line_o;
	end
	assign muxed_line_i = (muxed_line_oe_b_o & (ph != 2'h0 ? mem[adr] : {8{div}})) | (~muxed_line_oe_b_o & muxed_line_o);
	assign serial0_alt_baud_clock_i = div[0];
	assign serial1_alt_baud_clock_i = div[1];
endmodule
`default_nettype wire

// >>> mabp_bus_tb.sv
/* Self-checking bench for mabp_bus.
 * Assumes checker and far model compiled first. */
`timescale 1ns/100ps
`default_nettype none
module mabp_bus_tb;
	logic        clock_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        req_valid_i, req_write_i, req_byte_i, req_refresh_i, copro_op_i, copro_busy_i;
	logic [19:0] req_addr_i;
	logic [15:0] req_wdata_i, muxed_line_i, muxed_line_o, muxed_line_oe_b_o, rsp_rdata_o, q;
	logic [3:0]  upper_addr_line_o;
	logic        req_ready_o, rsp_valid_o, stall_o, addr_strobe_o, upper_byte_en_b_o;
	logic        serial0_alt_baud_clock_i, serial1_alt_baud_clock_i, serial0_baud_tick_o, serial1_baud_tick_o;
	integer      fail_count = 0;
	integer      cmp_count = 0;
	integer      n, k, t0, t1;
	mabp_bus i_mabp_bus (.*);
	mabp_far i_mabp_far (.*);
	always #25 clock_i = ~clock_i;
	task end_of_test; begin
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	end endtask
	task chk(input string nm, input [15:0] s, input [15:0] e); begin
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			fail_count = fail_count + 1;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	end endtask
	task cyc(input [19:0] a, input [2:0] f, input [15:0] d, input u); begin
		{req_refresh_i, req_byte_i, req_write_i} = f;
		req_addr_i = a;
		req_wdata_i = d;
		req_valid_i = 1'b1;
		n = 0;
		@(negedge clock_i);
		while (req_ready_o !== 1'b1 && n < 40) begin
			@(negedge clock_i);
			n = n + 1;
		end
		@(posedge clock_i);
		#1 req_valid_i = 1'b0;
		@(negedge clock_i);
		chk("ube", 16'(upper_byte_en_b_o), 16'(u));
		while (rsp_valid_o !== 1'b1 && n < 80) begin
			@(negedge clock_i);
			n = n + 1;
		end
		chk("rsp", 16'(rsp_valid_o), 16'h1);
		q = rsp_rdata_o;
		@(posedge clock_i);
		#1;
	end endtask
	task t_types; begin
		for (k = 0; k < 4; k = k + 1) cyc({16'h9a5c, 1'b0, k[0], 1'b0, k[1]}, {k == 3, k == 1 || k == 2, k != 3}, 16'h1234 + k[15:0], k[0]);
		for (k = 0; k < 3; k = k + 1) begin
			cyc({16'h9a5c, 1'b0, k[0], 1'b0, k[1]}, {1'b0, k != 0, 1'b0}, 16'h0, k[0]);
			chk("rdata", q, 16'h1234 + k[15:0]);
		end
	end endtask
	task t_stall; begin
		copro_busy_i = 1'b1;
		copro_op_i = 1'b1;
		repeat (3) @(negedge clock_i);
		chk("rdy", 16'(req_ready_o), 16'h0);
		@(posedge clock_i);
		#1;
		fork
			cyc(20'h9a5c0, 3'b000, 16'h0, 1'b0);
			begin repeat (4) @(posedge clock_i); #1 copro_busy_i = 1'b0; end
		join
		chk("resume", q, 16'h1234);
		copro_op_i = 1'b0;
	end endtask
	task t_baud; begin
		t0 = 0;
		t1 = 0;
		repeat (40) begin
			@(negedge clock_i);
			t0 = t0 + serial0_baud_tick_o;
			t1 = t1 + serial1_baud_tick_o;
		end
		chk("tick0", t0[15:0], 16'h14);
		chk("tick1", t1[15:0], 16'h0a);
	end endtask
	initial begin
		{req_valid_i, req_write_i, req_byte_i, req_refresh_i, copro_op_i, copro_busy_i, req_addr_i, req_wdata_i} = '0;
		repeat (16) @(posedge clock_i);
		#1 rst_b_i = 1'b1;
		t_types;
		t_stall;
		t_baud;
		end_of_test;
	end
	initial begin
		#20000 fail_count = fail_count + 1;
		end_of_test;
	end
endmodule
`default_nettype wire
